// *** aspc_pkg.sv ***
// constants, field layout and state types of the asynchronous serial port
//
// Notes on behaviour
// - frames are accepted only while the receive enable bit is one.
// - in 9-bit mode the ninth transmit bit goes out; ignored in 8-bit mode.
// - ninth receive bit gets stop bit in 8-bit mode, ninth data bit in 9-bit.
// - transmit-done sets after eighth bit, or at stop bit start in 9-bit mode.
// - receive-done sets when an accepted byte's stop bit is sampled.
// - with its mask bit set, either done flag raises the interrupt request.
// - hardware never clears the done flags; software clears each by writing.
// - writing the data address while idle loads the shift register and starts sending.
// - reading the data address returns the receive latch, same address.
// - mode select zero means 8-bit frames, one means 9-bit frames.
// - 8-bit mode with multiprocessor enable needs stop bit one to accept.
// - load only with receive-done clear; 9-bit multiprocessor needs ninth bit one.
// - a 9-bit frame is start, eight data LSB first, ninth, stop.
`default_nettype none
package aspc_pkg;
  // register indexes; byte address is four times the index
  localparam logic [9:0] CTRL_IDX = 10'h098;
  localparam logic [9:0] DATA_IDX = 10'h099;
  localparam logic [9:0] MASK_IDX = 10'h09a;
  localparam logic [11:0] CTRL_ADDR = {CTRL_IDX, 2'b00};
  localparam logic [11:0] DATA_ADDR = {DATA_IDX, 2'b00};
  localparam logic [11:0] MASK_ADDR = {MASK_IDX, 2'b00};
  // control register fields
  localparam int MODE_BIT = 7;
  localparam int ONE_BIT = 6;
  localparam int MCE_BIT = 5;
  localparam int REN_BIT = 4;
  localparam int TB8_BIT = 3;
  localparam int RB8_BIT = 2;
  localparam int TXF_BIT = 1;
  localparam int RXF_BIT = 0;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
  // bit timing: the rate tick comes at sixteen per bit
  localparam logic [3:0] TICKS_LAST = 4'hf;
  localparam logic [3:0] TICKS_HALF = 4'h8;
  localparam logic [3:0] TICKS_ZERO = 4'h0;
  localparam logic [2:0] LAST_DATA = 3'h7;
  localparam logic [2:0] BIT_ZERO = 3'h0;
  localparam logic [2:0] BIT_ONE = 3'h1;
  // frame states, gray coded along the 9-bit frame
  typedef enum logic [2:0] {
    ASPC_IDLE = 3'b000,
    ASPC_START = 3'b001,
    ASPC_DATA = 3'b011,
    ASPC_NINTH = 3'b010,
    ASPC_STOP = 3'b110
  } aspc_state_t;
endpackage
`default_nettype wire

// *** aspc_flag_if.sv ***
// set, clear and value of one sticky status flag
`default_nettype none
interface aspc_flag_if;
  logic set;
  logic clr;
  logic q;
  modport owner (input set, input clr, output q);
  modport user (output set, output clr, input q);
endinterface
`default_nettype wire

// *** aspc_flag.sv ***
// one sticky flag, set by hardware, cleared by software
`default_nettype none
module aspc_flag (
  input wire logic pclk,
  input wire logic presetn,
  aspc_flag_if.owner f
);
  logic q_reg;
  logic q_next;

  // set beats a clear in the same cycle; only software clears
  always_comb begin
    q_next = f.set | (q_reg & ~f.clr);
  end

  // flag register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_reg <= 1'b0;
    end else begin
      q_reg <= q_next;
    end
  end

  assign f.q = q_reg;
endmodule
`default_nettype wire

// *** aspc_bit_timer.sv ***
// per-bit strobe made from the sixteen-per-bit rate tick
`default_nettype none
module aspc_bit_timer #(
  parameter logic [3:0] PRELOAD = 4'h0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic rate_tick,
  input wire logic restart,
  output logic bit_strobe
);
  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;

  // count ticks; preload sets where in the bit the strobe falls
  always_comb begin
    cnt_next = cnt_reg;
    if (restart) begin
      cnt_next = PRELOAD;
    end else if (rate_tick) begin
      cnt_next = cnt_reg + 4'h1;
    end
  end

  // tick counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= aspc_pkg::TICKS_ZERO;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign bit_strobe = rate_tick & ~restart & (cnt_reg == aspc_pkg::TICKS_LAST);
endmodule
`default_nettype wire

// *** aspc_serial_port.sv ***
// serial port top: apb registers, transmitter, receiver, interrupt
`default_nettype none
module aspc_serial_port (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rate_tick,
  input wire logic serial_rx,
  output logic serial_tx,
  output logic irq
);
  ////////////////////////////////////////////////////////////////////////
  // register state
  logic frame_mode_select_reg;
  logic frame_mode_select_next;
  logic multiproc_enable_reg;
  logic multiproc_enable_next;
  logic rx_enable_bit_reg;
  logic rx_enable_bit_next;
  logic tx_ninth_bit_reg;
  logic tx_ninth_bit_next;
  logic rx_ninth_bit_reg;
  logic rx_ninth_bit_next;
  logic [7:0] rx_latch_reg;
  logic [7:0] rx_latch_next;
  logic [1:0] mask_reg;
  logic [1:0] mask_next;
  logic irq_reg;
  logic irq_next;
  logic pready_reg;
  logic pready_next;
  logic pslverr_reg;
  logic pslverr_next;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic [7:0] ctrl_view;
  logic bus_done;
  logic wr_ctrl;
  logic wr_data;
  logic wr_mask;
  logic lane0;
  logic mapped;
  logic tx_load;
  logic rx_accept;

  aspc_flag_if txf ();
  aspc_flag_if rxf ();

  ////////////////////////////////////////////////////////////////////////
  // sticky done flags
  aspc_flag u_tx_flag (
    .pclk(pclk),
    .presetn(presetn),
    .f(txf)
  );

  aspc_flag u_rx_flag (
    .pclk(pclk),
    .presetn(presetn),
    .f(rxf)
  );

  ////////////////////////////////////////////////////////////////////////
  // apb decode: one wait state, writes land on the pready edge
  assign bus_done = psel & penable & pready_reg;
  assign lane0 = pstrb[0];
  assign mapped = (paddr == aspc_pkg::CTRL_ADDR) | (paddr == aspc_pkg::DATA_ADDR) |
                  (paddr == aspc_pkg::MASK_ADDR);
  assign wr_ctrl = bus_done & pwrite & lane0 & (paddr == aspc_pkg::CTRL_ADDR);
  assign wr_data = bus_done & pwrite & lane0 & (paddr == aspc_pkg::DATA_ADDR);
  assign wr_mask = bus_done & pwrite & lane0 & (paddr == aspc_pkg::MASK_ADDR);

  // control register as software sees it; spare bit reads one
  always_comb begin
    ctrl_view = 8'h00;
    ctrl_view[aspc_pkg::MODE_BIT] = frame_mode_select_reg;
    ctrl_view[aspc_pkg::ONE_BIT] = 1'b1;
    ctrl_view[aspc_pkg::MCE_BIT] = multiproc_enable_reg;
    ctrl_view[aspc_pkg::REN_BIT] = rx_enable_bit_reg;
    ctrl_view[aspc_pkg::TB8_BIT] = tx_ninth_bit_reg;
    ctrl_view[aspc_pkg::RB8_BIT] = rx_ninth_bit_reg;
    ctrl_view[aspc_pkg::TXF_BIT] = txf.q;
    ctrl_view[aspc_pkg::RXF_BIT] = rxf.q;
  end

  // bus answer: pready one cycle into the access phase
  always_comb begin
    pready_next = psel & penable & ~pready_reg;
    pslverr_next = pslverr_reg;
    prdata_next = prdata_reg;
    if (psel & penable & ~pready_reg) begin
      pslverr_next = ~mapped;
      prdata_next = aspc_pkg::ZERO_WORD;
      if (!pwrite) begin
        if (paddr == aspc_pkg::CTRL_ADDR) begin
          prdata_next = {24'h00_0000, ctrl_view};
        end else if (paddr == aspc_pkg::DATA_ADDR) begin
          prdata_next = {24'h00_0000, rx_latch_reg};
        end else if (paddr == aspc_pkg::MASK_ADDR) begin
          prdata_next = {30'h0000_0000, mask_reg};
        end
      end
    end else if (pready_reg) begin
      pslverr_next = 1'b0;
    end
  end

  // bus answer registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= aspc_pkg::ZERO_WORD;
    end else begin
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      prdata_reg <= prdata_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // transmitter
  aspc_pkg::aspc_state_t tx_state_reg;
  aspc_pkg::aspc_state_t tx_state_next;
  logic [7:0] tx_shift_reg;
  logic [7:0] tx_shift_next;
  logic [2:0] tx_count_reg;
  logic [2:0] tx_count_next;
  logic tx_line_reg;
  logic tx_line_next;
  logic tx_strobe;

  aspc_bit_timer #(
    .PRELOAD(aspc_pkg::TICKS_ZERO)
  ) u_tx_timer (
    .pclk(pclk),
    .presetn(presetn),
    .rate_tick(rate_tick),
    .restart(tx_load),
    .bit_strobe(tx_strobe)
  );

  // a write while a frame is going out is dropped, so no frame is cut short
  assign tx_load = wr_data & (tx_state_reg == aspc_pkg::ASPC_IDLE);

  // frame sequencer; done is flagged as the stop bit begins
  always_comb begin
    tx_state_next = tx_state_reg;
    tx_shift_next = tx_shift_reg;
    tx_count_next = tx_count_reg;
    tx_line_next = tx_line_reg;
    txf.set = 1'b0;
    case (tx_state_reg)
      aspc_pkg::ASPC_IDLE: begin
        tx_line_next = 1'b1;
        if (tx_load) begin
          tx_shift_next = pwdata[7:0];
          tx_count_next = aspc_pkg::BIT_ZERO;
          tx_line_next = 1'b0;
          tx_state_next = aspc_pkg::ASPC_START;
        end
      end
      aspc_pkg::ASPC_START: begin
        if (tx_strobe) begin
          tx_line_next = tx_shift_reg[0];
          tx_state_next = aspc_pkg::ASPC_DATA;
        end
      end
      aspc_pkg::ASPC_DATA: begin
        if (tx_strobe) begin
          tx_shift_next = {1'b0, tx_shift_reg[7:1]};
          tx_count_next = tx_count_reg + aspc_pkg::BIT_ONE;
          if (tx_count_reg != aspc_pkg::LAST_DATA) begin
            tx_line_next = tx_shift_reg[1];
          end else if (frame_mode_select_reg) begin
            tx_line_next = tx_ninth_bit_reg;
            tx_state_next = aspc_pkg::ASPC_NINTH;
          end else begin
            tx_line_next = 1'b1;
            txf.set = 1'b1;
            tx_state_next = aspc_pkg::ASPC_STOP;
          end
        end
      end
      aspc_pkg::ASPC_NINTH: begin
        if (tx_strobe) begin
          tx_line_next = 1'b1;
          txf.set = 1'b1;
          tx_state_next = aspc_pkg::ASPC_STOP;
        end
      end
      aspc_pkg::ASPC_STOP: begin
        if (tx_strobe) begin
          tx_state_next = aspc_pkg::ASPC_IDLE;
        end
      end
      default: begin
        tx_line_next = 1'b1;
        tx_state_next = aspc_pkg::ASPC_IDLE;
      end
    endcase
  end

  // transmitter registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_state_reg <= aspc_pkg::ASPC_IDLE;
      tx_shift_reg <= aspc_pkg::DATA_RESET;
      tx_count_reg <= aspc_pkg::BIT_ZERO;
      tx_line_reg <= 1'b1;
    end else begin
      tx_state_reg <= tx_state_next;
      tx_shift_reg <= tx_shift_next;
      tx_count_reg <= tx_count_next;
      tx_line_reg <= tx_line_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // receiver
  aspc_pkg::aspc_state_t rx_state_reg;
  aspc_pkg::aspc_state_t rx_state_next;
  logic [7:0] rx_shift_reg;
  logic [7:0] rx_shift_next;
  logic [2:0] rx_count_reg;
  logic [2:0] rx_count_next;
  logic rx_bit9_reg;
  logic rx_bit9_next;
  logic rx_prev_reg;
  logic rx_prev_next;
  logic rx_strobe;
  logic rx_begin;
  logic rx_check;

  // preload half a bit so samples fall mid-bit
  aspc_bit_timer #(
    .PRELOAD(aspc_pkg::TICKS_HALF)
  ) u_rx_timer (
    .pclk(pclk),
    .presetn(presetn),
    .rate_tick(rate_tick),
    .restart(rx_begin),
    .bit_strobe(rx_strobe)
  );

  // start is a falling edge, so a line left low by a bad stop bit starts no phantom frame
  assign rx_begin = (rx_state_reg == aspc_pkg::ASPC_IDLE) & rx_enable_bit_reg &
                    rx_prev_reg & ~serial_rx;

  // accept test at stop sampling: flag clear, then the mode's address check
  always_comb begin
    rx_check = ~rxf.q;
    if (multiproc_enable_reg) begin
      if (frame_mode_select_reg) begin
        rx_check = ~rxf.q & rx_bit9_reg;
      end else begin
        rx_check = ~rxf.q & serial_rx;
      end
    end
  end

  // frame sequencer; a false start or dropped enable returns to idle
  always_comb begin
    rx_state_next = rx_state_reg;
    rx_shift_next = rx_shift_reg;
    rx_count_next = rx_count_reg;
    rx_bit9_next = rx_bit9_reg;
    rx_prev_next = serial_rx;
    rx_accept = 1'b0;
    case (rx_state_reg)
      aspc_pkg::ASPC_IDLE: begin
        if (rx_begin) begin
          rx_count_next = aspc_pkg::BIT_ZERO;
          rx_state_next = aspc_pkg::ASPC_START;
        end
      end
      aspc_pkg::ASPC_START: begin
        if (rx_strobe) begin
          rx_state_next = serial_rx ? aspc_pkg::ASPC_IDLE : aspc_pkg::ASPC_DATA;
        end
      end
      aspc_pkg::ASPC_DATA: begin
        if (rx_strobe) begin
          rx_shift_next = {serial_rx, rx_shift_reg[7:1]};
          rx_count_next = rx_count_reg + aspc_pkg::BIT_ONE;
          if (rx_count_reg == aspc_pkg::LAST_DATA) begin
            rx_state_next = frame_mode_select_reg ? aspc_pkg::ASPC_NINTH :
                            aspc_pkg::ASPC_STOP;
          end
        end
      end
      aspc_pkg::ASPC_NINTH: begin
        if (rx_strobe) begin
          rx_bit9_next = serial_rx;
          rx_state_next = aspc_pkg::ASPC_STOP;
        end
      end
      aspc_pkg::ASPC_STOP: begin
        if (rx_strobe) begin
          rx_accept = rx_check;
          rx_state_next = aspc_pkg::ASPC_IDLE;
        end
      end
      default: begin
        rx_state_next = aspc_pkg::ASPC_IDLE;
      end
    endcase
    if (!rx_enable_bit_reg) begin
      rx_state_next = aspc_pkg::ASPC_IDLE;
      rx_accept = 1'b0;
    end
  end

  // receiver registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_state_reg <= aspc_pkg::ASPC_IDLE;
      rx_shift_reg <= aspc_pkg::DATA_RESET;
      rx_count_reg <= aspc_pkg::BIT_ZERO;
      rx_bit9_reg <= 1'b0;
      rx_prev_reg <= 1'b1;
    end else begin
      rx_state_reg <= rx_state_next;
      rx_shift_reg <= rx_shift_next;
      rx_count_reg <= rx_count_next;
      rx_bit9_reg <= rx_bit9_next;
      rx_prev_reg <= rx_prev_next;
    end
  end

  assign rxf.set = rx_accept;

  ////////////////////////////////////////////////////////////////////////
  // software registers; flag bits clear by writing one
  always_comb begin
    frame_mode_select_next = frame_mode_select_reg;
    multiproc_enable_next = multiproc_enable_reg;
    rx_enable_bit_next = rx_enable_bit_reg;
    tx_ninth_bit_next = tx_ninth_bit_reg;
    rx_ninth_bit_next = rx_ninth_bit_reg;
    rx_latch_next = rx_latch_reg;
    mask_next = mask_reg;
    txf.clr = wr_ctrl & pwdata[aspc_pkg::TXF_BIT];
    rxf.clr = wr_ctrl & pwdata[aspc_pkg::RXF_BIT];
    if (wr_ctrl) begin
      frame_mode_select_next = pwdata[aspc_pkg::MODE_BIT];
      multiproc_enable_next = pwdata[aspc_pkg::MCE_BIT];
      rx_enable_bit_next = pwdata[aspc_pkg::REN_BIT];
      tx_ninth_bit_next = pwdata[aspc_pkg::TB8_BIT];
      rx_ninth_bit_next = pwdata[aspc_pkg::RB8_BIT];
    end
    if (wr_mask) begin
      mask_next = pwdata[1:0];
    end
    // hardware load wins over a software write of the ninth bit
    if (rx_accept) begin
      rx_latch_next = rx_shift_reg;
      rx_ninth_bit_next = frame_mode_select_reg ? rx_bit9_reg : serial_rx;
    end
    // level request while any enabled flag stands
    irq_next = |(mask_reg & {txf.q, rxf.q});
  end

  // software register file
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_mode_select_reg <= 1'b0;
      multiproc_enable_reg <= 1'b0;
      rx_enable_bit_reg <= 1'b0;
      tx_ninth_bit_reg <= 1'b0;
      rx_ninth_bit_reg <= 1'b0;
      rx_latch_reg <= aspc_pkg::DATA_RESET;
      mask_reg <= 2'b00;
      irq_reg <= 1'b0;
    end else begin
      frame_mode_select_reg <= frame_mode_select_next;
      multiproc_enable_reg <= multiproc_enable_next;
      rx_enable_bit_reg <= rx_enable_bit_next;
      tx_ninth_bit_reg <= tx_ninth_bit_next;
      rx_ninth_bit_reg <= rx_ninth_bit_next;
      rx_latch_reg <= rx_latch_next;
      mask_reg <= mask_next;
      irq_reg <= irq_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs, all from flip-flops
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign serial_tx = tx_line_reg;
  assign irq = irq_reg;
endmodule
`default_nettype wire

// *** aspc_checker.sv ***
// port-level timing checks of the serial port: apb handshake and serial line
`default_nettype none
module aspc_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic rate_tick,
  input wire logic serial_rx,
  input wire logic serial_tx,
  input wire logic irq
);
  logic [7:0] hi_reg;
  logic [7:0] hi_next;
  logic wr_any;
  logic wr_data;
  logic idle;
  //////////////////////////////////////////////////////////////////////////////
  // completed writes; idle means more high ticks than any frame can hold
  assign wr_any = psel && penable && pready && pwrite;
  assign wr_data = wr_any && pstrb[0] && paddr == aspc_pkg::DATA_ADDR;
  assign idle = hi_reg >= 8'hc0;
  // ticks counted with the line high, saturating
  always_comb begin
    hi_next = hi_reg;
    if (!serial_tx) begin
      hi_next = 8'h00;
    end else if (rate_tick && hi_reg != 8'hff) begin
      hi_next = hi_reg + 8'h01;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hi_reg <= 8'h00;
    end else begin
      hi_reg <= hi_next;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_access;
    psel && !penable ##1 psel && penable;
  endsequence
  property p_one_wait;
    s_access |-> !pready ##1 pready;
  endproperty
  property p_pulse;
    pready |=> !pready;
  endproperty
  property p_ready_in_access;
    pready |-> psel && penable;
  endproperty
  property p_err_zero;
    pslverr |-> pready && prdata == 32'h0000_0000;
  endproperty
  property p_upper_zero;
    pready && !pwrite |-> prdata[31:8] == 24'h00_0000;
  endproperty
  property p_tx_start;
    idle && wr_data |=> !serial_tx;
  endproperty
  property p_tx_cause;
    idle && $fell(serial_tx) |-> $past(wr_data);
  endproperty
  property p_tx_tick;
    $changed(serial_tx) && !$past(wr_data) |-> $past(rate_tick) || $past(rate_tick, 2);
  endproperty
  property p_irq_fall;
    $fell(irq) |-> $past(wr_any) || $past(wr_any, 2) || $past(wr_any, 3);
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("apb answer not after one wait");
  a_pulse: assert property (p_pulse) else $error("pready longer than one cycle");
  a_ready_in_access: assert property (p_ready_in_access) else $error("pready outside access");
  a_err_zero: assert property (p_err_zero) else $error("error without zero data");
  a_upper_zero: assert property (p_upper_zero) else $error("upper read bits set");
  a_tx_start: assert property (p_tx_start) else $error("no start bit after write");
  a_tx_cause: assert property (p_tx_cause) else $error("start bit without write");
  a_tx_tick: assert property (p_tx_tick) else $error("line moved off a tick");
  a_irq_fall: assert property (p_irq_fall) else $error("irq fell without a write");
endmodule
`default_nettype wire

// *** aspc_remote.sv ***
// remote transceiver: sends frames on serial_rx, captures frames from serial_tx
`default_nettype none
module aspc_remote (
  input wire logic pclk,
  input wire logic rate_tick,
  input wire logic serial_tx,
  output logic serial_rx
);
  initial serial_rx = 1'b1;
  // wait for n rate ticks; returns just after a clock edge
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge pclk);
      while (rate_tick !== 1'b1) @(posedge pclk);
    end
  endtask
  // start, data lsb first, ninth in 9-bit frames, stop; line idles high after
  task automatic send(input logic [7:0] d, input logic nine, input logic ninth, input logic st);
    logic [10:0] f;
    f = nine ? {st, ninth, d, 1'b0} : {1'b1, st, d, 1'b0};
    for (int i = 0; i < (nine ? 11 : 10); i++) begin
      serial_rx <= f[i];
      ticks(16);
    end
    serial_rx <= 1'b1;
  endtask
  // mid-bit sampling; a missing start bit gives up after a bounded wait
  task automatic grab(input int n, output logic [9:0] b);
    int w;
    w = 0;
    b = 10'h3ff;
    while (serial_tx !== 1'b0 && w < 4000) begin
      @(posedge pclk);
      w++;
    end
    ticks(8);
    for (int i = 0; i < n; i++) begin
      ticks(16);
      b[i] = serial_tx;
    end
  endtask
endmodule
`default_nettype wire

// *** aspc_tb.sv ***
// self-checking bench of the serial port
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0] pstrb = 4'hf;
  logic rate_tick = 1'b0;
  logic [1:0] tick_cnt = 2'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic serial_rx;
  logic serial_tx;
  logic irq;
  logic [31:0] rdv;
  logic errv;
  logic [9:0] bits;
  int failures = 0;
  int num_checks = 0;
  localparam logic [11:0] CA = aspc_pkg::CTRL_ADDR;
  localparam logic [11:0] DA = aspc_pkg::DATA_ADDR;
  localparam logic [11:0] MA = aspc_pkg::MASK_ADDR;
  //////////////////////////////////////////////////////////////////////////////
  always #2.5 pclk = ~pclk;
  // rate tick every fourth cycle stands in for the timer overflow
  always @(posedge pclk) begin
    tick_cnt <= tick_cnt + 2'h1;
    rate_tick <= tick_cnt == 2'h3;
  end
  aspc_serial_port aspc_serial_port_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .rate_tick(rate_tick),
    .serial_rx(serial_rx), .serial_tx(serial_tx), .irq(irq));
  aspc_remote aspc_remote_i (.pclk(pclk), .rate_tick(rate_tick), .serial_tx(serial_tx),
    .serial_rx(serial_rx));
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one apb transfer; waits for pready, a dead slave is caught by the watchdog
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rdv, exp);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    rd(CA, 32'h0000_0040);
    rd(DA, 32'h0000_0000);
    rd(MA, 32'h0000_0000);
    apb(1'b0, 12'h100, 32'h0000_0000);
    chk(32'(errv), 32'h0000_0001);
    $display("test regs done");
  endtask
  // one transmitted frame: data, ninth or stop, done flag, irq, clearing
  task automatic t_tx(input logic mode, input logic nb, input logic [7:0] d);
    logic [31:0] c;
    c = {24'h00_0000, mode, 3'h0, nb, 3'h0};
    apb(1'b1, MA, 32'h0000_0002);
    apb(1'b1, CA, c);
    aspc_remote_i.ticks(200);
    apb(1'b1, DA, 32'(d));
    aspc_remote_i.grab(mode ? 10 : 9, bits);
    chk(32'(bits[7:0]), 32'(d));
    chk(32'(bits[8]), 32'(mode ? nb : 1'b1));
    rd(CA, c | 32'h0000_0042);
    chk(32'(irq), 32'h0000_0001);
    apb(1'b1, CA, c | 32'h0000_0002);
    rd(CA, c | 32'h0000_0040);
    chk(32'(irq), 32'h0000_0000);
    $display("test tx done");
  endtask
  // reception: enable, latch, ninth bit, refusals while flagged or filtered
  task automatic t_rx();
    apb(1'b1, CA, 32'h0000_0000);
    apb(1'b1, MA, 32'h0000_0001);
    aspc_remote_i.send(8'h11, 1'b0, 1'b0, 1'b1);
    rd(CA, 32'h0000_0040);
    apb(1'b1, CA, 32'h0000_0010);
    aspc_remote_i.send(8'h5a, 1'b0, 1'b0, 1'b1);
    rd(DA, 32'h0000_005a);
    rd(CA, 32'h0000_0055);
    chk(32'(irq), 32'h0000_0001);
    aspc_remote_i.send(8'h66, 1'b0, 1'b0, 1'b1);
    rd(DA, 32'h0000_005a);
    apb(1'b1, CA, 32'h0000_0031);
    rd(CA, 32'h0000_0070);
    aspc_remote_i.send(8'h77, 1'b0, 1'b0, 1'b0);
    rd(CA, 32'h0000_0070);
    apb(1'b1, CA, 32'h0000_00b0);
    aspc_remote_i.send(8'h88, 1'b1, 1'b0, 1'b1);
    rd(CA, 32'h0000_00f0);
    aspc_remote_i.send(8'h99, 1'b1, 1'b1, 1'b1);
    rd(DA, 32'h0000_0099);
    rd(CA, 32'h0000_00f5);
    apb(1'b1, CA, 32'h0000_0091);
    aspc_remote_i.send(8'h42, 1'b1, 1'b0, 1'b1);
    rd(CA, 32'h0000_00d1);
    rd(DA, 32'h0000_0042);
    $display("test rx done");
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_tx(1'b0, 1'b1, 8'ha5);
    t_tx(1'b1, 1'b1, 8'h3c);
    t_tx(1'b1, 1'b0, 8'hc3);
    t_rx();
    end_of_test();
  end
  // watchdog well beyond the expected run of some nine thousand cycles
  initial begin
    #150000;
    failures++;
    end_of_test();
  end
endmodule
bind aspc_serial_port aspc_checker aspc_checker_i (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .rate_tick(rate_tick), .serial_rx(serial_rx), .serial_tx(serial_tx), .irq(irq));
`default_nettype wire
